// file: logic/rtr_pkg.sv
package rtr_pkg;
   localparam int NUM_PINS = 24;
   localparam int PIN_W = 5;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] PATH_CFG_IDX = 8'h03;
   localparam logic [7:0] TABLE_FIRST_IDX = 8'h10;
   localparam logic [7:0] TABLE_LAST_IDX = 8'h3f;
   localparam logic [7:0] EOI_IDX = 8'h40;
   localparam int PATH_SEL_BIT = 0;
   localparam int VEC_LSB = 0;
   localparam int VEC_W = 8;
   localparam int DLV_LSB = 8;
   localparam int DLV_W = 3;
   localparam int DEST_MODE_BIT = 11;
   localparam int STATUS_BIT = 12;
   localparam int POL_BIT = 13;
   localparam int REMOTE_BIT = 14;
   localparam int TRIG_BIT = 15;
   localparam int MASK_BIT = 16;
   localparam int DEST_LSB = 24;
   localparam int DEST_W = 8;
   localparam int PHYS_ID_W = 4;
   localparam logic RST_MASK = 1'b1;
   localparam logic RST_PATH_SEL = 1'b0;
   localparam logic [7:0] RST_VEC = 8'h00;
   localparam logic [7:0] RST_DEST = 8'h00;
   localparam logic [2:0] RST_DLV = 3'h0;
   localparam logic [2:0] DLV_FIXED = 3'h0;
   localparam logic [2:0] DLV_LOWEST = 3'h1;
   localparam logic [2:0] DLV_SYS_MGMT = 3'h2;
   localparam logic [2:0] DLV_RSVD_A = 3'h3;
   localparam logic [2:0] DLV_NMI = 3'h4;
   localparam logic [2:0] DLV_INIT = 3'h5;
   localparam logic [2:0] DLV_RSVD_B = 3'h6;
   localparam logic [2:0] DLV_EXT_LEGACY = 3'h7;
endpackage : rtr_pkg

// file: logic/rtr_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtr_link_if #(
   parameter int N = rtr_pkg::NUM_PINS
);
   logic [N-1:0] req;
   logic [rtr_pkg::PIN_W-1:0] scan_idx;
   logic [7:0] vec;
   logic [7:0] dest;
   logic [2:0] dlv;
   logic dest_logical;
   logic level;
   logic busy;
   logic [rtr_pkg::PIN_W-1:0] busy_idx;
   logic done;
   logic accepted;
   modport table_side (
      output req, vec, dest, dlv, dest_logical, level,
      input scan_idx, busy, busy_idx, done, accepted
   );
   modport sender_side (
      input req, vec, dest, dlv, dest_logical, level,
      output scan_idx, busy, busy_idx, done, accepted
   );
endinterface : rtr_link_if
`default_nettype wire

// file: logic/rtr_sender.sv
`timescale 1ns/1ns
`default_nettype none
module rtr_sender #(
   parameter int NUM_PINS = rtr_pkg::NUM_PINS
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   rtr_link_if.sender_side link,
   input wire logic path_sel_i,
   input wire logic msg_done_i,
   input wire logic msg_accept_i,
   output logic msg_serial_valid_o,
   output logic msg_fsb_valid_o,
   output logic [7:0] msg_vector_o,
   output logic [7:0] msg_dest_o,
   output logic msg_dest_logical_o,
   output logic [2:0] msg_delivery_mode_o,
   output logic msg_level_o,
   output logic [rtr_pkg::PIN_W-1:0] msg_pin_o
);
   localparam logic [rtr_pkg::PIN_W-1:0] LAST_PIN = rtr_pkg::PIN_W'(NUM_PINS - 1);
   logic [rtr_pkg::PIN_W-1:0] ptr_r;
   logic busy_r;
   logic path_r;
   logic grant;

   assign grant = !busy_r && link.req[ptr_r];
   assign link.scan_idx = ptr_r;
   assign link.busy = busy_r;
   assign link.busy_idx = msg_pin_o;
   assign link.done = busy_r && msg_done_i;
   assign link.accepted = msg_accept_i;
   // Message goes out on the serial bus or as a front-side bus message.
   assign msg_serial_valid_o = busy_r && !path_r;
   assign msg_fsb_valid_o = busy_r && path_r;

   // The scan pointer walks through the entries while no message is out.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr_r <= '0;
      end else if (!busy_r) begin
         ptr_r <= (ptr_r == LAST_PIN) ? '0 : ptr_r + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_r <= 1'b0;
      end else if (grant) begin
         busy_r <= 1'b1;
      end else if (msg_done_i) begin
         busy_r <= 1'b0;
      end
   end

   // The selected entry is latched so it stands unchanged until the bus unit confirms.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         path_r <= rtr_pkg::RST_PATH_SEL;
         msg_pin_o <= '0;
         msg_vector_o <= '0;
         msg_dest_o <= '0;
         msg_dest_logical_o <= 1'b0;
         msg_delivery_mode_o <= '0;
         msg_level_o <= 1'b0;
      end else if (grant) begin
         path_r <= path_sel_i;
         msg_pin_o <= ptr_r;
         msg_vector_o <= link.vec;
         msg_dest_o <= link.dest;
         msg_dest_logical_o <= link.dest_logical;
         msg_delivery_mode_o <= link.dlv;
         msg_level_o <= link.level;
      end
   end
endmodule : rtr_sender
`default_nettype wire

// file: logic/rtr_redirection_table.sv
// Contract
// - Delivery path bit 0 sends on serial bus, 1 as front-side message.
// - One 64-bit entry per pin, two 32-bit halves at consecutive indexes.
// - Detection sets delivery status; new edge only after send confirmed.
// - Physical mode uses 4-bit destination id, logical uses full 8 bits.
// - Mask blocks delivery and pending; message already out is unaffected.
// - Trigger mode bit 0 means edge, 1 means level.
// - Remote-accept set on level acceptance, cleared by end-of-interrupt.
// - Polarity bit 0 means active high, 1 means active low.
// - Delivery status is read-only: 1 while waiting, 0 idle.
// - Reset sets mask and clears bits fifteen to twelve.
// - End-of-interrupt write clears remote-accept of every matching vector; an entry accepted in the same cycle keeps it set.
// - Vector held in the low eight bits of each entry.
// - Three-bit delivery mode; non-maskable and init never set remote-accept.
`timescale 1ns/1ns
`default_nettype none
module rtr_redirection_table #(
   parameter int NUM_PINS = rtr_pkg::NUM_PINS
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [rtr_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [rtr_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [rtr_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic [NUM_PINS-1:0] irq_pin_i,
   input wire logic eoi_msg_valid_i,
   input wire logic [7:0] eoi_msg_vector_i,
   input wire logic msg_done_i,
   input wire logic msg_accept_i,
   output logic msg_serial_valid_o,
   output logic msg_fsb_valid_o,
   output logic [7:0] msg_vector_o,
   output logic [7:0] msg_dest_o,
   output logic msg_dest_logical_o,
   output logic [2:0] msg_delivery_mode_o,
   output logic msg_level_o,
   output logic [rtr_pkg::PIN_W-1:0] msg_pin_o,
   output logic delivery_path_select_o
);
   rtr_link_if #(.N(NUM_PINS)) link ();

   logic delivery_path_select_r;
   logic [7:0] vec_r [NUM_PINS];
   logic [2:0] dlv_r [NUM_PINS];
   logic [7:0] dest_r [NUM_PINS];
   logic dest_mode_r [NUM_PINS];
   logic status_r [NUM_PINS];
   logic pol_r [NUM_PINS];
   logic remote_r [NUM_PINS];
   logic trig_r [NUM_PINS];
   logic mask_r [NUM_PINS];
   logic prev_r [NUM_PINS];

   logic in_table;
   logic [7:0] tab_off;
   logic [rtr_pkg::PIN_W-1:0] ent_idx;
   logic hi_half;
   logic eoi_wr;
   logic [rtr_pkg::DATA_W-1:0] rd_val;
   logic [rtr_pkg::PIN_W-1:0] rd_ent;

   assign in_table = (reg_addr_i >= rtr_pkg::TABLE_FIRST_IDX) &&
                     (reg_addr_i <= rtr_pkg::TABLE_LAST_IDX);
   assign tab_off = reg_addr_i - rtr_pkg::TABLE_FIRST_IDX;
   assign ent_idx = tab_off[rtr_pkg::PIN_W:1];
   assign hi_half = tab_off[0];
   assign eoi_wr = reg_wr_i && (reg_addr_i == rtr_pkg::EOI_IDX);
   assign rd_ent = ent_idx;
   assign delivery_path_select_o = delivery_path_select_r;

   // Delivery path configuration.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         delivery_path_select_r <= rtr_pkg::RST_PATH_SEL;
      end else if (reg_wr_i && reg_addr_i == rtr_pkg::PATH_CFG_IDX) begin
         delivery_path_select_r <= reg_wdata_i[rtr_pkg::PATH_SEL_BIT];
      end
   end

   // Fields of the selected entry handed to the sender.
   always_comb begin
      link.vec = vec_r[link.scan_idx];
      link.dlv = dlv_r[link.scan_idx];
      link.dest_logical = dest_mode_r[link.scan_idx];
      link.level = trig_r[link.scan_idx];
      if (dest_mode_r[link.scan_idx]) begin
         link.dest = dest_r[link.scan_idx];
      end else begin
         link.dest = {{(rtr_pkg::DEST_W - rtr_pkg::PHYS_ID_W){1'b0}},
                      dest_r[link.scan_idx][rtr_pkg::PHYS_ID_W-1:0]};
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_ent
         logic wr_lo;
         logic wr_hi;
         logic active;
         logic trigger;
         logic in_flight;
         logic done_me;
         logic eoi_hit;
         logic no_remote;

         assign wr_lo = reg_wr_i && in_table && !hi_half && ent_idx == rtr_pkg::PIN_W'(g);
         assign wr_hi = reg_wr_i && in_table && hi_half && ent_idx == rtr_pkg::PIN_W'(g);
         assign active = irq_pin_i[g] ^ pol_r[g];
         assign in_flight = link.busy && link.busy_idx == rtr_pkg::PIN_W'(g);
         assign done_me = link.done && link.busy_idx == rtr_pkg::PIN_W'(g);
         assign no_remote = (dlv_r[g] == rtr_pkg::DLV_NMI) ||
                            (dlv_r[g] == rtr_pkg::DLV_INIT);
         assign eoi_hit = (eoi_wr && reg_wdata_i[7:0] == vec_r[g]) ||
                          (eoi_msg_valid_i && eoi_msg_vector_i == vec_r[g]);
         // Edge entries fire on a fresh edge only while idle; level entries while active with remote-accept clear.
         assign trigger = !mask_r[g] && !status_r[g] &&
                          (trig_r[g] ? (active && !remote_r[g])
                                     : (active && !prev_r[g]));
         assign link.req[g] = status_r[g] && !mask_r[g];

         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               prev_r[g] <= 1'b0;
            end else begin
               prev_r[g] <= active;
            end
         end

         // Writable fields of the low half.
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               mask_r[g] <= rtr_pkg::RST_MASK;
               trig_r[g] <= 1'b0;
               pol_r[g] <= 1'b0;
               dest_mode_r[g] <= 1'b0;
               dlv_r[g] <= rtr_pkg::RST_DLV;
               vec_r[g] <= rtr_pkg::RST_VEC;
            end else if (wr_lo) begin
               mask_r[g] <= reg_wdata_i[rtr_pkg::MASK_BIT];
               trig_r[g] <= reg_wdata_i[rtr_pkg::TRIG_BIT];
               pol_r[g] <= reg_wdata_i[rtr_pkg::POL_BIT];
               dest_mode_r[g] <= reg_wdata_i[rtr_pkg::DEST_MODE_BIT];
               dlv_r[g] <= reg_wdata_i[rtr_pkg::DLV_LSB +: rtr_pkg::DLV_W];
               vec_r[g] <= reg_wdata_i[rtr_pkg::VEC_LSB +: rtr_pkg::VEC_W];
            end
         end

         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               dest_r[g] <= rtr_pkg::RST_DEST;
            end else if (wr_hi) begin
               dest_r[g] <= reg_wdata_i[rtr_pkg::DEST_LSB +: rtr_pkg::DEST_W];
            end
         end

         // Delivery status: set on detection, cleared once the message is accepted.
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               status_r[g] <= 1'b0;
            end else if (done_me && link.accepted) begin
               status_r[g] <= 1'b0;
            end else if (trigger) begin
               status_r[g] <= 1'b1;
            end else if (mask_r[g] && !in_flight) begin
               status_r[g] <= 1'b0;
            end
         end

         // Remote-accept: acceptance wins over a clear arriving in the same cycle.
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               remote_r[g] <= 1'b0;
            end else if (done_me && link.accepted && trig_r[g] && !no_remote) begin
               remote_r[g] <= 1'b1;
            end else if (eoi_hit) begin
               remote_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Read multiplexer; reserved bits read as zero.
   always_comb begin
      rd_val = '0;
      if (reg_addr_i == rtr_pkg::PATH_CFG_IDX) begin
         rd_val[rtr_pkg::PATH_SEL_BIT] = delivery_path_select_r;
      end else if (in_table && hi_half) begin
         rd_val[rtr_pkg::DEST_LSB +: rtr_pkg::DEST_W] = dest_r[rd_ent];
      end else if (in_table) begin
         rd_val[rtr_pkg::MASK_BIT] = mask_r[rd_ent];
         rd_val[rtr_pkg::TRIG_BIT] = trig_r[rd_ent];
         rd_val[rtr_pkg::REMOTE_BIT] = remote_r[rd_ent];
         rd_val[rtr_pkg::POL_BIT] = pol_r[rd_ent];
         rd_val[rtr_pkg::STATUS_BIT] = status_r[rd_ent];
         rd_val[rtr_pkg::DEST_MODE_BIT] = dest_mode_r[rd_ent];
         rd_val[rtr_pkg::DLV_LSB +: rtr_pkg::DLV_W] = dlv_r[rd_ent];
         rd_val[rtr_pkg::VEC_LSB +: rtr_pkg::VEC_W] = vec_r[rd_ent];
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_val;
      end else begin
         reg_rdata_o <= '0;
      end
   end

   rtr_sender #(.NUM_PINS(NUM_PINS)) u_sender (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .link(link),
      .path_sel_i(delivery_path_select_r),
      .msg_done_i(msg_done_i),
      .msg_accept_i(msg_accept_i),
      .msg_serial_valid_o(msg_serial_valid_o),
      .msg_fsb_valid_o(msg_fsb_valid_o),
      .msg_vector_o(msg_vector_o),
      .msg_dest_o(msg_dest_o),
      .msg_dest_logical_o(msg_dest_logical_o),
      .msg_delivery_mode_o(msg_delivery_mode_o),
      .msg_level_o(msg_level_o),
      .msg_pin_o(msg_pin_o)
   );
endmodule : rtr_redirection_table
`default_nettype wire

// file: tb/rtr_redirection_table_props.sv
`timescale 1ns/1ns
`default_nettype none
module rtr_redirection_table_props (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic msg_done_i,
   input wire logic msg_serial_valid_o,
   input wire logic msg_fsb_valid_o,
   input wire logic [7:0] msg_vector_o,
   input wire logic [7:0] msg_dest_o,
   input wire logic msg_dest_logical_o,
   input wire logic [4:0] msg_pin_o,
   input wire logic delivery_path_select_o
);
   wire logic v = msg_serial_valid_o | msg_fsb_valid_o;
   wire logic tab = reg_rd_i && reg_addr_i >= 8'h10 && reg_addr_i <= 8'h3f;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   one_path_a: assert property (!(msg_serial_valid_o && msg_fsb_valid_o))
      else $error("both message paths valid");
   path_sel_a: assert property (v |-> msg_serial_valid_o == !delivery_path_select_o)
      else $error("message on wrong path");
   path_write_a: assert property (reg_wr_i && reg_addr_i == 8'h03 |=>
      delivery_path_select_o == $past(reg_wdata_i[0]))
      else $error("path bit not written");
   phys_dest_a: assert property (v && !msg_dest_logical_o |-> msg_dest_o[7:4] == 4'h0)
      else $error("physical destination too wide");
   msg_hold_a: assert property (v && !msg_done_i |=>
      v && $stable(msg_vector_o) && $stable(msg_pin_o))
      else $error("message dropped before done");
   msg_drop_a: assert property (v && msg_done_i |=> !v)
      else $error("message stands after done");
   rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside read slot");
   hi_rsvd_a: assert property (tab && reg_addr_i[0] |=> reg_rdata_o[23:0] == 24'h0)
      else $error("high word reserved bits set");
   lo_rsvd_a: assert property (tab && !reg_addr_i[0] |=> reg_rdata_o[31:17] == 15'h0)
      else $error("low word reserved bits set");
   eoi_rd_a: assert property (reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == 32'h0)
      else $error("end of interrupt register readable");
endmodule : rtr_redirection_table_props
bind rtr_redirection_table rtr_redirection_table_props rtr_redirection_table_props_i (
   .mclk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .msg_done_i, .msg_serial_valid_o, .msg_fsb_valid_o, .msg_vector_o, .msg_dest_o,
   .msg_dest_logical_o, .msg_pin_o, .delivery_path_select_o);
`default_nettype wire

// file: tb/rtr_bus_unit_model.sv
`timescale 1ns/1ns
`default_nettype none
module rtr_bus_unit_model (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic valid_i,
   input wire logic [2:0] delay_i,
   input wire logic refuse_i,
   output logic done_o,
   output logic accept_o
);
   logic [2:0] cnt_r;
   // The answer is meaningful only with done; otherwise it toggles.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= 3'h0;
         done_o <= 1'b0;
         accept_o <= 1'b0;
      end else if (!valid_i || done_o) begin
         cnt_r <= 3'h0;
         done_o <= 1'b0;
         accept_o <= ~accept_o;
      end else if (cnt_r == delay_i) begin
         done_o <= 1'b1;
         accept_o <= ~refuse_i;
      end else begin
         cnt_r <= cnt_r + 3'h1;
         accept_o <= ~accept_o;
      end
   end
endmodule : rtr_bus_unit_model
`default_nettype wire

// file: tb/test_rtr_redirection_table.sv
`timescale 1ns/1ns
`default_nettype none
module test_rtr_redirection_table;
   logic mclk_i, reset_n_i, reg_wr_i, reg_rd_i, eoi_msg_valid_i, msg_done_i, msg_accept_i;
   logic [7:0] reg_addr_i, eoi_msg_vector_i, msg_vector_o, msg_dest_o, v;
   logic [31:0] reg_wdata_i, reg_rdata_o, rs, lo, d, e;
   logic [23:0] irq_pin_i;
   logic sv, fv, dl, lv, path, refuse;
   logic [2:0] dm, dly;
   logic [4:0] pin, n;
   int n_errors, num_checks, cyc;
   rtr_redirection_table rtr_redirection_table_i (.mclk_i, .reset_n_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_pin_i, .eoi_msg_valid_i,
      .eoi_msg_vector_i, .msg_done_i, .msg_accept_i, .msg_serial_valid_o(sv),
      .msg_fsb_valid_o(fv), .msg_vector_o, .msg_dest_o, .msg_dest_logical_o(dl),
      .msg_delivery_mode_o(dm), .msg_level_o(lv), .msg_pin_o(pin), .delivery_path_select_o(path));
   rtr_bus_unit_model rtr_bus_unit_model_i (.mclk_i, .reset_n_i, .valid_i(sv | fv),
      .delay_i(dly), .refuse_i(refuse), .done_o(msg_done_i), .accept_o(msg_accept_i));
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   function logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   function logic [7:0] ia(input logic [4:0] k);
      return 8'h10 + {2'b0, k, 1'b0};
   endfunction : ia
   function logic [31:0] lo_exp(input logic [31:0] x);
      return x & 32'h0001afff;
   endfunction : lo_exp
   task report_and_stop();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= x;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(negedge mclk_i);
      chk(reg_rdata_o, exp);
   endtask : rd
   task set_e(input logic [4:0] k, input logic [31:0] x, input logic [7:0] dst);
      wr(ia(k) + 8'h1, {dst, 24'h0});
      wr(ia(k), x);
   endtask : set_e
   task wait_v(input logic want);
      int i;
      for (i = 0; i < 80; i++) begin
         @(negedge mclk_i);
         if ((sv | fv) === want) break;
      end
      if (i == 80) chk(32'h0, 32'h1);
   endtask : wait_v
   task no_msg(input int k);
      repeat (k) begin
         @(negedge mclk_i);
         chk({31'h0, sv | fv}, 32'h0);
      end
   endtask : no_msg
   task eoi(input logic [7:0] x);
      @(posedge mclk_i);
      eoi_msg_valid_i <= 1'b1;
      eoi_msg_vector_i <= x;
      @(posedge mclk_i);
      eoi_msg_valid_i <= 1'b0;
   endtask : eoi
   initial begin
      rs = 32'h819e650c;
      {n_errors, num_checks, cyc} = '0;
      {reset_n_i, reg_wr_i, reg_rd_i, eoi_msg_valid_i, refuse} = '0;
      {reg_addr_i, eoi_msg_vector_i, reg_wdata_i, irq_pin_i, dly} = '0;
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rd(8'h10, 32'h00010000);
      rd(8'h3e, 32'h00010000);
      rd(8'h03, 32'h0);
      $display("reset test done");
      for (int k = 0; k < 12; k++) begin
         n = 5'(rnd() % 24);
         d = rnd() | 32'h00015000;
         e = rnd();
         wr(ia(n), d);
         wr(ia(n) + 8'h1, e);
         rd(ia(n), lo_exp(d));
         rd(ia(n) + 8'h1, e & 32'hff000000);
      end
      wr(8'h05, rnd());
      rd(8'h05, 32'h0);
      wr(8'h03, 32'hfffffffe);
      rd(8'h03, 32'h0);
      $display("register test done");
      for (int c = 0; c < 8; c++) if (c != 3 && c != 6) begin
         n = 5'(rnd() % 24);
         v = 8'h10 + 8'(rnd() % 239);
         e = rnd();
         dly = 3'h1 + 3'(rnd() % 7);
         refuse <= (c == 0);
         lo = {21'h0, c[2:0], v};
         set_e(n, lo, e[7:0]);
         @(posedge mclk_i);
         irq_pin_i[n] <= 1'b1;
         wait_v(1'b1);
         chk({sv, fv, lv, dl, dm, pin, msg_vector_o, msg_dest_o},
            {4'h8, c[2:0], n, v, 4'h0, e[3:0]});
         @(posedge mclk_i);
         irq_pin_i[n] <= 1'b0;
         @(posedge mclk_i);
         irq_pin_i[n] <= 1'b1;
         if (c == 0) begin
            wait_v(1'b0);
            rd(ia(n), lo | 32'h1000);
            refuse <= 1'b0;
            wait_v(1'b1);
         end
         wait_v(1'b0);
         no_msg(40);
         rd(ia(n), lo);
         irq_pin_i[n] <= 1'b0;
      end
      $display("edge test done");
      dly = 3'h7;
      wr(8'h03, 32'h1);
      lo = 32'h0000a800 | {24'h0, v};
      set_e(5'd5, lo, e[7:0]);
      irq_pin_i[5] <= 1'b1;
      @(posedge mclk_i);
      irq_pin_i[5] <= 1'b0;
      wait_v(1'b1);
      chk({sv, fv, lv, dl, dm, pin, msg_vector_o, msg_dest_o},
         {4'h7, 3'h0, 5'd5, v, e[7:0]});
      wait_v(1'b0);
      rd(8'h1a, lo | 32'h4000);
      no_msg(40);
      eoi(v ^ 8'h01);
      no_msg(30);
      wr(8'h40, {24'hffffff, v});
      wait_v(1'b1);
      wait_v(1'b0);
      wr(8'h1a, lo | 32'h00010000);
      eoi(v);
      no_msg(30);
      irq_pin_i[5] <= 1'b1;
      rd(8'h1a, lo | 32'h00010000);
      wr(8'h03, 32'h0);
      $display("level test done");
      set_e(5'd9, 32'h00010000 | {24'h0, v}, 8'h0);
      irq_pin_i[9] <= 1'b1;
      no_msg(40);
      rd(8'h22, 32'h00010000 | {24'h0, v});
      wr(8'h22, {24'h0, v});
      no_msg(40);
      $display("mask test done");
      report_and_stop();
   end
endmodule : test_rtr_redirection_table
`default_nettype wire
